// ==== rtl/htm_pkg.sv ====
// constants, codes and carriers for the humidity and temperature controller
// assumes a 50 MHz system clock and an I2C controller on the far side
package htm_pkg;

  // link addressing
  localparam logic [6:0] TARGET_ADDR = 7'h28;
  localparam logic [7:0] CTRL_ADDR = 8'h0C;
  localparam logic [7:0] STATUS_ADDR = 8'h0D;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] BIT_MSB = 4'h7;
  localparam logic [1:0] RESULT_LAST_BYTE = 2'h3;

  // operating-state field codes
  localparam logic [2:0] SET_SLEEP = 3'h0;
  localparam logic [2:0] SET_MEAS = 3'h1;
  localparam logic [2:0] SET_RESET = 3'h4;

  // standby-interval field codes
  localparam logic [2:0] STBY_100 = 3'h2;
  localparam logic [2:0] STBY_400 = 3'h3;
  localparam logic [2:0] STBY_1000 = 3'h4;
  localparam logic [2:0] STBY_ONESHOT = 3'h7;

  localparam logic [7:0] CTRL_RESET = 8'h00;

  // timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned STBY_100_MS = 100;
  localparam int unsigned STBY_400_MS = 400;
  localparam int unsigned STBY_1000_MS = 1000;
  localparam int unsigned WAKE_TIME_US = 100;
  localparam int unsigned STBY_100_CYC = STBY_100_MS * (CLK_HZ / 1000);
  localparam int unsigned STBY_400_CYC = STBY_400_MS * (CLK_HZ / 1000);
  localparam int unsigned STBY_1000_CYC = STBY_1000_MS * (CLK_HZ / 1000);
  localparam int unsigned WAKE_CYC = WAKE_TIME_US * (CLK_HZ / 1_000_000);

  // controller states, gray along sleep-meas-standby-wake
  typedef enum logic [2:0] {
    HTM_SLEEP = 3'h0,
    HTM_MEAS = 3'h1,
    HTM_STBY = 3'h3,
    HTM_WAKE = 3'h2,
    HTM_BOOT = 3'h6
  } htm_state_e;

  // link phases
  typedef enum logic [1:0] {
    LNK_IDLE = 2'h0,
    LNK_ADDR = 2'h1,
    LNK_WR = 2'h3,
    LNK_RD = 2'h2
  } htm_link_e;

  // control register layout
  typedef struct packed {
    logic rsvd;
    logic [2:0] standby_interval_sel;
    logic heater_en;
    logic [2:0] set_state;
  } htm_ctrl_s;

  typedef struct packed {
    logic [15:0] humidity;
    logic [15:0] temperature;
  } htm_result_s;

  // status byte: rsvd, state[2:0], rsvd, load fault, heater fault, ready
  typedef struct packed {
    logic rsvd_hi;
    logic [2:0] op_state;
    logic rsvd_lo;
    logic load_fault_flag;
    logic heater_fault;
    logic result_ready;
  } htm_status_s;

  typedef struct packed {
    htm_status_s status;
    htm_result_s result;
  } htm_view_s;

endpackage

// ==== rtl/htm_sync.sv ====
// three-stage synchroniser bank with agreement filter
// assumes inputs are asynchronous levels; output moves when stages 2 and 3 agree
`timescale 1ns/1ps
module htm_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] stable_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] stable_reg;
  wire logic [W-1:0] agree = ~(s2_reg ^ s3_reg);
  wire logic [W-1:0] stable_next = (agree & s3_reg) | (~agree & stable_reg);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      stable_reg <= '0;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      stable_reg <= stable_next;
    end
  end

  assign stable_o = stable_reg;
endmodule

// ==== rtl/htm_measure_ctrl.sv ====
// humidity and temperature measurement controller with I2C target link
// assumes scl_i/sda_i come from the bus pins; conversion and boot load are
// external engines handshaking on mclk_i
//
// Notes on behaviour
// - answer only target address 28h
// - writes set control; plain reads return results
// - pointer write then repeated start reads status
// - sleep state plus repeat and one-shot measurement
// - 001b with valid interval cycles measure/standby
// - 001b with 111b measures once, then sleeps
// - each finished conversion replaces held result
// - ready flag set when new result stored
// - heater bit drives heater, resets off
// - heater current fault shown in status
// - 100b resets registers, boot loads, then sleeps
// - failed boot load sleeps with fault flag
// - nack accesses during standby to measurement wake
// - interval ignored unless state field is 001b
// - interval codes 100, 400, 1000 ms
`timescale 1ns/1ps
module htm_measure_ctrl #(
  parameter int unsigned STBY_100_CYC_P = htm_pkg::STBY_100_CYC,
  parameter int unsigned STBY_400_CYC_P = htm_pkg::STBY_400_CYC,
  parameter int unsigned STBY_1000_CYC_P = htm_pkg::STBY_1000_CYC,
  parameter int unsigned WAKE_CYC_P = htm_pkg::WAKE_CYC
) (
  // system clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // I2C pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // conversion engine
  output logic conv_start_o,
  input wire logic conv_done_i,
  input wire htm_pkg::htm_result_s conv_result_i,
  // boot load engine
  output logic boot_start_o,
  input wire logic boot_done_i,
  input wire logic boot_fail_i,
  // heater
  output logic heater_en_o,
  input wire logic heater_fault_i,
  // state view
  output htm_pkg::htm_state_e op_state_o,
  output logic result_ready_o,
  output logic load_fault_flag_o
);
  import htm_pkg::*;

  // ---------------- link domain (scl) ----------------
  logic start_tgl_reg;
  logic start_seen_reg;
  htm_link_e ph_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic [7:0] ptr_reg;
  logic ptr_set_reg;
  logic sel_status_reg;
  logic [1:0] idx_reg;
  logic wr_tgl_reg;
  htm_ctrl_s wr_data_reg;
  logic rd_tgl_reg;
  logic hold_reg;
  logic oe_n_reg;
  logic block_lnk;
  logic block_reg;
  htm_view_s view_reg;

  // start seen as sda falling while scl high
  always_ff @(negedge sda_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_tgl_reg <= 1'b0;
    end else if (scl_i) begin
      start_tgl_reg <= ~start_tgl_reg;
    end
  end

  // wake/boot refusal level, filtered on scl
  htm_sync #(.W(1)) u_block_sync (
    .clk_i(scl_i),
    .rst_n_i(rst_n_i),
    .async_i(block_reg),
    .stable_o(block_lnk)
  );

  wire logic new_start = start_tgl_reg != start_seen_reg;
  wire logic at_ack = cnt_reg == ACK_SLOT;
  wire logic addr_hit = (sh_reg[7:1] == TARGET_ADDR) && !block_lnk;
  wire logic is_read = sh_reg[0];
  wire logic [7:0] sh_next = {sh_reg[6:0], sda_i};
  wire logic [3:0] cnt_inc = cnt_reg + 4'h1;
  wire logic [1:0] idx_inc = idx_reg + 2'h1;
  wire logic ptr_is_status = ptr_set_reg && (ptr_reg == STATUS_ADDR);
  wire logic ptr_is_ctrl = ptr_reg == CTRL_ADDR;
  wire logic [2:0] bit_sel = 3'(BIT_MSB - cnt_reg);
  wire logic [7:0] res_byte =
    (idx_reg == 2'h0) ? view_reg.result.humidity[15:8] :
    (idx_reg == 2'h1) ? view_reg.result.humidity[7:0] :
    (idx_reg == 2'h2) ? view_reg.result.temperature[15:8] :
    view_reg.result.temperature[7:0];
  wire logic [7:0] tx_byte = sel_status_reg ? view_reg.status : res_byte;
  wire logic ack_drive = ((ph_reg == LNK_ADDR) && at_ack && addr_hit) ||
                         ((ph_reg == LNK_WR) && at_ack);
  wire logic rd_drive = (ph_reg == LNK_RD) && !at_ack && !tx_byte[bit_sel];

  // bits sampled on scl rising
  always_ff @(posedge scl_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_seen_reg <= 1'b0;
      ph_reg <= LNK_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      ptr_set_reg <= 1'b0;
      sel_status_reg <= 1'b0;
      idx_reg <= 2'h0;
      wr_tgl_reg <= 1'b0;
      wr_data_reg <= CTRL_RESET;
      rd_tgl_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else if (new_start) begin
      start_seen_reg <= start_tgl_reg;
      ph_reg <= LNK_ADDR;
      cnt_reg <= 4'h1;
      sh_reg <= {7'h00, sda_i};
      hold_reg <= 1'b0;
    end else begin
      case (ph_reg)
        LNK_ADDR: begin
          if (!at_ack) begin
            sh_reg <= sh_next;
            cnt_reg <= cnt_inc;
          end else begin
            cnt_reg <= 4'h0;
            idx_reg <= 2'h0;
            if (!addr_hit) begin
              ph_reg <= LNK_IDLE;
            end else if (is_read) begin
              ph_reg <= LNK_RD;
              hold_reg <= 1'b1;
              sel_status_reg <= ptr_is_status;
              ptr_set_reg <= 1'b0;
            end else begin
              ph_reg <= LNK_WR;
            end
          end
        end
        LNK_WR: begin
          if (!at_ack) begin
            sh_reg <= sh_next;
            cnt_reg <= cnt_inc;
          end else begin
            cnt_reg <= 4'h0;
            idx_reg <= 2'h1;
            if (idx_reg == 2'h0) begin
              ptr_reg <= sh_reg;
              ptr_set_reg <= 1'b1;
            end else if (ptr_is_ctrl) begin
              wr_data_reg <= sh_reg;
              wr_tgl_reg <= ~wr_tgl_reg;
            end
          end
        end
        LNK_RD: begin
          if (!at_ack) begin
            cnt_reg <= cnt_inc;
          end else begin
            cnt_reg <= 4'h0;
            idx_reg <= idx_inc;
            if (!sel_status_reg && idx_reg == RESULT_LAST_BYTE) begin
              rd_tgl_reg <= ~rd_tgl_reg;
            end
            if (sda_i) begin
              ph_reg <= LNK_IDLE;
              hold_reg <= 1'b0;
            end
          end
        end
        default: begin
          ph_reg <= LNK_IDLE;
        end
      endcase
    end
  end

  // sda driven on scl falling
  always_ff @(negedge scl_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_n_reg <= 1'b1;
    end else begin
      oe_n_reg <= ~(ack_drive | rd_drive);
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n_o = oe_n_reg;

  // ---------------- system domain (mclk) ----------------
  logic [3:0] cross_stable;
  logic [3:0] cross_d_reg;
  htm_state_e st_reg;
  htm_state_e st_next;
  logic [31:0] tmr_reg;
  logic [31:0] tmr_next;
  htm_ctrl_s ctrl_reg;
  htm_result_s result_reg;
  logic rdy_reg;
  logic load_fault_reg;
  logic oneshot_reg;
  logic conv_start_reg;
  logic boot_start_reg;
  logic [31:0] stby_cyc;

  htm_sync #(.W(4)) u_cross_sync (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i({heater_fault_i, hold_reg, rd_tgl_reg, wr_tgl_reg}),
    .stable_o(cross_stable)
  );

  wire logic wr_evt = cross_stable[0] ^ cross_d_reg[0];
  wire logic rd_evt = cross_stable[1] ^ cross_d_reg[1];
  wire logic hold_sys = cross_stable[2];
  wire logic heat_fault = cross_stable[3];

  wire logic cmd_reset = wr_evt && (wr_data_reg.set_state == SET_RESET);
  wire logic cmd_oneshot = wr_evt && (wr_data_reg.set_state == SET_MEAS) &&
                           (wr_data_reg.standby_interval_sel == STBY_ONESHOT);
  wire logic is_meas = ctrl_reg.set_state == SET_MEAS;
  wire logic sel_100 = ctrl_reg.standby_interval_sel == STBY_100;
  wire logic sel_400 = ctrl_reg.standby_interval_sel == STBY_400;
  wire logic sel_1000 = ctrl_reg.standby_interval_sel == STBY_1000;
  wire logic rep_mode = is_meas && (sel_100 || sel_400 || sel_1000);
  wire logic sleep_mode = ctrl_reg.set_state == SET_SLEEP;
  wire logic meas_done = (st_reg == HTM_MEAS) && conv_done_i;
  wire logic boot_end = (st_reg == HTM_BOOT) && boot_done_i;
  wire logic tmr_zero = tmr_reg == 32'h0;
  wire logic [31:0] tmr_dec = tmr_reg - 32'h1;
  wire logic enter_meas = (st_next == HTM_MEAS) && (st_reg != HTM_MEAS);
  wire logic enter_boot = (st_next == HTM_BOOT) && cmd_reset;
  wire logic oneshot_finish = meas_done && oneshot_reg;

  assign stby_cyc = sel_100 ? STBY_100_CYC_P : (sel_400 ? STBY_400_CYC_P : STBY_1000_CYC_P);

  // operating-state sequencing
  always_comb begin
    st_next = st_reg;
    tmr_next = tmr_reg;
    case (st_reg)
      HTM_SLEEP: begin
        if (oneshot_reg || rep_mode) begin
          st_next = HTM_MEAS;
        end
      end
      HTM_MEAS: begin
        if (conv_done_i) begin
          if (rep_mode && !oneshot_reg) begin
            st_next = HTM_STBY;
            tmr_next = stby_cyc - 32'h1;
          end else begin
            st_next = HTM_SLEEP;
          end
        end
      end
      HTM_STBY: begin
        if (sleep_mode) begin
          st_next = HTM_SLEEP;
        end else if (oneshot_reg) begin
          st_next = HTM_MEAS;
        end else if (rep_mode && tmr_zero) begin
          st_next = HTM_WAKE;
          tmr_next = WAKE_CYC_P - 32'h1;
        end else if (rep_mode) begin
          tmr_next = tmr_dec;
        end
      end
      HTM_WAKE: begin
        if (tmr_zero) begin
          st_next = HTM_MEAS;
        end else begin
          tmr_next = tmr_dec;
        end
      end
      HTM_BOOT: begin
        if (boot_done_i) begin
          st_next = HTM_SLEEP;
        end
      end
      default: begin
        st_next = HTM_SLEEP;
      end
    endcase
    if (cmd_reset) begin
      st_next = HTM_BOOT;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= HTM_SLEEP;
      tmr_reg <= 32'h0;
      cross_d_reg <= 4'h0;
      conv_start_reg <= 1'b0;
      boot_start_reg <= 1'b0;
      block_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      tmr_reg <= tmr_next;
      cross_d_reg <= cross_stable;
      conv_start_reg <= enter_meas;
      boot_start_reg <= enter_boot;
      block_reg <= (st_next == HTM_WAKE) || (st_next == HTM_BOOT);
    end
  end

  // control register, result and flags
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= CTRL_RESET;
      result_reg <= '0;
      rdy_reg <= 1'b0;
      load_fault_reg <= 1'b0;
      oneshot_reg <= 1'b0;
    end else if (cmd_reset) begin
      ctrl_reg <= CTRL_RESET;
      result_reg <= '0;
      rdy_reg <= 1'b0;
      load_fault_reg <= 1'b0;
      oneshot_reg <= 1'b0;
    end else begin
      if (wr_evt) begin
        ctrl_reg <= wr_data_reg;
      end else if (oneshot_finish) begin
        ctrl_reg.set_state <= SET_SLEEP;
      end
      if (meas_done) begin
        result_reg <= conv_result_i;
      end
      rdy_reg <= meas_done | (rdy_reg & ~rd_evt);
      if (boot_end && boot_fail_i) begin
        load_fault_reg <= 1'b1;
      end
      oneshot_reg <= cmd_oneshot | (oneshot_reg & ~meas_done);
    end
  end

  // read view frozen while a read frame runs
  wire htm_status_s status_w = '{
    rsvd_hi: 1'b0,
    op_state: st_reg,
    rsvd_lo: 1'b0,
    load_fault_flag: load_fault_reg,
    heater_fault: heat_fault,
    result_ready: rdy_reg
  };

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      view_reg <= '0;
    end else if (!hold_sys) begin
      view_reg <= '{status: status_w, result: result_reg};
    end
  end

  assign conv_start_o = conv_start_reg;
  assign boot_start_o = boot_start_reg;
  assign heater_en_o = ctrl_reg.heater_en;
  assign op_state_o = st_reg;
  assign result_ready_o = rdy_reg;
  assign load_fault_flag_o = load_fault_reg;
endmodule

// ==== verification/htm_measure_ctrl_props.sv ====
// assertions on the controller state view and engine start pulses
// assumes binding onto htm_measure_ctrl, all in the mclk_i domain
`timescale 1ns/1ps
module htm_measure_ctrl_props #(
  parameter int unsigned STBY_1000_CYC_P = 80,
  parameter int unsigned WAKE_CYC_P = 10
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // engines and state view
  input wire logic conv_start_o,
  input wire logic conv_done_i,
  input wire logic boot_start_o,
  input wire logic boot_done_i,
  input wire logic boot_fail_i,
  input wire logic heater_en_o,
  input wire htm_pkg::htm_state_e op_state_o,
  input wire logic result_ready_o,
  input wire logic load_fault_flag_o
);
  import htm_pkg::*;
  logic [31:0] stby_cnt_reg;
  logic [31:0] wake_cnt_reg;
  wire [31:0] stby_cnt_next = (op_state_o == HTM_STBY) ? stby_cnt_reg + 1 : '0;
  wire [31:0] wake_cnt_next = (op_state_o == HTM_WAKE) ? wake_cnt_reg + 1 : '0;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stby_cnt_reg <= '0;
      wake_cnt_reg <= '0;
    end else begin
      stby_cnt_reg <= stby_cnt_next;
      wake_cnt_reg <= wake_cnt_next;
    end
  end
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  rst_idle_a: assert property (
    $rose(rst_n_i) |-> op_state_o == HTM_SLEEP && !heater_en_o && !result_ready_o)
    else $error("state view not idle after reset");
  conv_pulse_a: assert property (
    conv_start_o |-> op_state_o == HTM_MEAS ##1 !conv_start_o)
    else $error("bad conversion start pulse");
  meas_done_a: assert property (
    op_state_o == HTM_MEAS && conv_done_i |=> result_ready_o && op_state_o != HTM_MEAS)
    else $error("finished conversion not taken");
  boot_pulse_a: assert property (
    boot_start_o |-> op_state_o == HTM_BOOT ##1 !boot_start_o)
    else $error("bad boot start pulse");
  boot_end_a: assert property (
    op_state_o == HTM_BOOT && boot_done_i |=> op_state_o == HTM_SLEEP
      && load_fault_flag_o == $past(boot_fail_i))
    else $error("boot end state or fault flag wrong");
  fault_sleep_a: assert property (
    load_fault_flag_o |-> op_state_o inside {HTM_SLEEP, HTM_BOOT})
    else $error("running with boot load fault");
  stby_wake_a: assert property (
    op_state_o == HTM_STBY |=> op_state_o != HTM_MEAS)
    else $error("standby skipped the wake window");
  stby_len_a: assert property (
    stby_cnt_reg <= STBY_1000_CYC_P + 1)
    else $error("standby too long");
  wake_len_a: assert property (
    wake_cnt_reg <= WAKE_CYC_P + 1)
    else $error("wake window too long");
endmodule

bind htm_measure_ctrl htm_measure_ctrl_props #(
  .STBY_1000_CYC_P(STBY_1000_CYC_P),
  .WAKE_CYC_P(WAKE_CYC_P)
) i_props (
  .mclk_i, .rst_n_i, .conv_start_o, .conv_done_i, .boot_start_o, .boot_done_i,
  .boot_fail_i, .heater_en_o, .op_state_o, .result_ready_o, .load_fault_flag_o
);

// ==== verification/htm_i2c_host.sv ====
// I2C controller model in place of the host microcontroller
// assumes the bench resolves SDA with a pull-up; scl stands high when idle
`timescale 1ns/1ps
module htm_i2c_host #(
  parameter int unsigned QTR_NS = 60,
  parameter int unsigned HOLD_NS = 3_000_000
) (
  // bus
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  import htm_pkg::*;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic bit_io(input logic low, output logic seen);
    sda_low_o = low;
    #QTR_NS scl_o = 1'b1;
    #QTR_NS seen = sda_i;
    #QTR_NS scl_o = 1'b0;
    #QTR_NS;
  endtask
  task automatic start();
    sda_low_o = 1'b0;
    #QTR_NS scl_o = 1'b1;
    #QTR_NS sda_low_o = 1'b1;
    #QTR_NS scl_o = 1'b0;
    #QTR_NS;
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    #QTR_NS scl_o = 1'b1;
    #QTR_NS sda_low_o = 1'b0;
    #QTR_NS;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(!b[i], s);
    end
    bit_io(1'b0, s);
    ack = !s;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b0, s);
      b = {b[6:0], s};
    end
    bit_io(!last, s);
  endtask
  task automatic probe(input logic [6:0] adr, output logic ack);
    start();
    wr_byte({adr, 1'b0}, ack);
    stop();
    if (!ack) begin
      #HOLD_NS;
    end
  endtask
  task automatic write_ctrl(input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    wr_byte({TARGET_ADDR, 1'b0}, a0);
    wr_byte(CTRL_ADDR, a1);
    wr_byte(d, a2);
    stop();
    ok = a0 & a1 & a2;
    if (d[2:0] == SET_RESET || !ok) begin
      #HOLD_NS;
    end
  endtask
  task automatic read_status(output logic [7:0] st);
    logic a;
    start();
    wr_byte({TARGET_ADDR, 1'b0}, a);
    wr_byte(STATUS_ADDR, a);
    start();
    wr_byte({TARGET_ADDR, 1'b1}, a);
    rd_byte(1'b1, st);
    stop();
  endtask
  task automatic read_result(output logic [31:0] r);
    logic a;
    logic [7:0] v;
    start();
    wr_byte({TARGET_ADDR, 1'b1}, a);
    for (int i = 3; i >= 0; i--) begin
      rd_byte(i == 0, v);
      r = {r[23:0], v};
    end
    stop();
  endtask
endmodule

// ==== verification/humidity_temp_measure_ctrl_tb_top.sv ====
// self-checking bench for the humidity and temperature controller
// assumes the host model on the bus and shortened interval counts
`timescale 1ns/1ps
module humidity_temp_measure_ctrl_tb_top;
  import htm_pkg::*;
  localparam int unsigned STBY_P[3] = '{400, 600, 800};
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b1;
  logic scl, sda_low, sda_o, sda_oe_n_o, conv_start_o, boot_start_o, heater_en_o, ack;
  logic result_ready_o, load_fault_flag_o;
  logic conv_done_i = 1'b0;
  logic boot_done_i = 1'b0;
  logic boot_fail_i = 1'b0;
  logic heater_fault_i = 1'b0;
  logic fail_sel = 1'b0;
  logic fault_sel = 1'b0;
  htm_result_s conv_result_i = '0;
  htm_state_e op_state_o;
  logic [7:0] res_n = 8'h00;
  logic [7:0] st;
  logic [31:0] res;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  int stby_run = 0;
  wire sda = ~sda_low & (sda_oe_n_o | sda_o);
  always #10 mclk_i = ~mclk_i;
  htm_measure_ctrl #(
    .STBY_100_CYC_P(STBY_P[0]), .STBY_400_CYC_P(STBY_P[1]),
    .STBY_1000_CYC_P(STBY_P[2]), .WAKE_CYC_P(200)
  ) i_dut (
    .mclk_i, .rst_n_i, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_n_o, .conv_start_o,
    .conv_done_i, .conv_result_i, .boot_start_o, .boot_done_i, .boot_fail_i,
    .heater_en_o, .heater_fault_i, .op_state_o, .result_ready_o, .load_fault_flag_o
  );
  htm_i2c_host #(.HOLD_NS(20_000)) i_host (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));
  // conversion and boot engines answer one cycle after their start
  always @(posedge mclk_i) begin
    conv_done_i <= conv_start_o;
    boot_done_i <= boot_start_o;
    boot_fail_i <= fail_sel;
    heater_fault_i <= fault_sel;
    cyc <= cyc + 1;
    if (conv_start_o) begin
      conv_result_i <= {8'hA5, res_n, 8'h3C, ~res_n};
      res_n <= res_n + 8'h01;
    end
    if (cyc == 40000) begin
      fail_count++;
      end_sim();
    end
  end
  // length of the current standby stretch, counted on falling edges
  always @(negedge mclk_i) begin
    stby_run <= (op_state_o === HTM_STBY) ? stby_run + 1 : 0;
  end
  function automatic logic [31:0] res_of(input logic [7:0] k);
    return {8'hA5, k, 8'h3C, ~k};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wait_st(input htm_state_e s);
    int k;
    k = 0;
    while (op_state_o !== s && k < 3000) begin
      @(negedge mclk_i);
      k++;
    end
    check("state", 32'(op_state_o), 32'(s));
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    // a real falling edge, so the scl-side flops reset before any frame
    rst_n_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(negedge mclk_i);
    check("heater", 32'(heater_en_o), 0);
    i_host.probe(7'h29, ack);
    check("ack other", 32'(ack), 0);
    i_host.probe(TARGET_ADDR, ack);
    check("ack own", 32'(ack), 1);
    fault_sel = 1'b1;
    i_host.write_ctrl(8'h08, ack);
    check("heater on", 32'(heater_en_o), 1);
    i_host.read_status(st);
    check("status", 32'(st), 32'h02);
    fault_sel = 1'b0;
    i_host.write_ctrl(8'h00, ack);
    check("heater off", 32'(heater_en_o), 0);
    for (int k = 1; k < 3; k++) begin
      i_host.write_ctrl(8'h71, ack);
      repeat (20) @(negedge mclk_i);
      check("convs", 32'(res_n), k);
      check("state", 32'(op_state_o), 32'(HTM_SLEEP));
      check("ready", 32'(result_ready_o), 1);
      i_host.read_result(res);
      check("result", res, res_of(8'(k - 1)));
    end
    i_host.write_ctrl(8'h70, ack);
    repeat (20) @(negedge mclk_i);
    check("ignored", 32'(res_n), 2);
    for (int c = 0; c < 3; c++) begin
      i_host.write_ctrl({1'b0, STBY_100 + 3'(c), 4'h1}, ack);
      wait_st(HTM_STBY);
      check("ready", 32'(result_ready_o), 1);
      n = 0;
      while (op_state_o === HTM_STBY && n < 2000) begin
        @(negedge mclk_i);
        n++;
      end
      check("stby", 32'(stby_run), STBY_P[c]);
      check("wake", 32'(op_state_o), 32'(HTM_WAKE));
      i_host.probe(TARGET_ADDR, ack);
      check("wake ack", 32'(ack), 0);
      wait_st(HTM_WAKE);
      wait_st(HTM_STBY);
      i_host.write_ctrl(8'h00, ack);
      check("sleep", 32'(op_state_o), 32'(HTM_SLEEP));
    end
    fail_sel = 1'b1;
    i_host.write_ctrl(8'h0C, ack);
    check("heater rst", 32'(heater_en_o), 0);
    check("fault", 32'(load_fault_flag_o), 1);
    i_host.read_status(st);
    check("status", 32'(st), 32'h04);
    fail_sel = 1'b0;
    i_host.write_ctrl(8'h04, ack);
    check("fault clr", 32'(load_fault_flag_o), 0);
    end_sim();
  end
endmodule
